/* File: eip_host_model.sv */
`timescale 1ns/10ps
// ==========================================================
// host side of the interrupt pin: pull-down, config drive,
// pulse counter and width meter
// ==========================================================
module eip_host_model (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_int_n,   // device drive value
  input  wire logic i_int_oe,  // device drives the pin
  input  wire logic i_cfg_drv, // host drives a config level
  input  wire logic i_cfg_lvl, // config level from host
  output logic      o_pin,     // resolved pin level
  output int        o_pulses,  // falls seen while device drives
  output int        o_last_low,
  output int        o_last_gap
);
  logic prev_r; // pin level at last edge
  int   run_r;  // cycles at the current level

  // unselected pin falls to the pull-down, never holds old value
  assign o_pin = i_int_oe ? i_int_n : (i_cfg_drv ? i_cfg_lvl : 1'b0);

  // measure each low and high stretch in whole cycles
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_r     <= 1'b1;
      run_r      <= 0;
      o_pulses   <= 0;
      o_last_low <= 0;
      o_last_gap <= 0;
    end else if (o_pin !== prev_r) begin
      prev_r <= o_pin;
      run_r  <= 1;
      // a fall ends the high gap, a rise ends the pulse
      if (!o_pin && i_int_oe) begin
        o_pulses   <= o_pulses + 1;
        o_last_gap <= run_r;
      end
      if (o_pin && i_int_oe) begin
        o_last_low <= run_r;
      end
    end else begin
      run_r <= run_r + 1;
    end
  end
endmodule

/* File: eip_pkg.sv */
package eip_pkg;

  // ==========================================================
  // clock and timing
  // ==========================================================
  localparam int CLK_MHZ  = 20;  // reference clock rate
  localparam int T_INT_US = 100; // low pulse width, us
  localparam int T_GAP_US = 100; // irq_min_gap, us
  localparam int T_CFG_US = 7;   // config select filter, us
  localparam int CNT_W    = 11;  // timer width

  // exact multiples, so no rounding is needed
  localparam logic [CNT_W-1:0] PULSE_CYC = CNT_W'(T_INT_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] GAP_CYC   = CNT_W'(T_GAP_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] CFG_CYC   = CNT_W'(T_CFG_US * CLK_MHZ);

  // ==========================================================
  // register map
  // ==========================================================
  localparam int AW = 8;  // address width
  localparam int DW = 32; // bus data width
  localparam int RW = 8;  // register width
  localparam logic [AW-1:0] REG_CTRL    = 8'h00;
  localparam logic [AW-1:0] REG_WAKE_EN_A = 8'h04;
  localparam logic [AW-1:0] REG_WAKE_EN_B = 8'h08;
  localparam logic [AW-1:0] REG_WAKE_A  = 8'h0C;
  localparam logic [AW-1:0] REG_WAKE_B  = 8'h10;
  localparam logic [AW-1:0] REG_FAIL    = 8'h14;
  localparam logic [AW-1:0] REG_PIN_LVL = 8'h18;
  localparam logic [AW-1:0] REG_DEV     = 8'h1C;
  localparam logic [AW-1:0] REG_IRQ_ST  = 8'h20;
  localparam logic [AW-1:0] REG_IRQ_MSK = 8'h24;

  // control fields and reset values
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_GLB_BIT  = 2;
  localparam logic [RW-1:0] WAKE_EN_RST = 8'h00;
  localparam logic [RW-1:0] IRQ_MSK_RST = 8'h00;
  // failure bits allowed to pulse in the global class
  localparam logic [RW-1:0] FAIL_IRQ_BITS = 8'hC0;
  // interrupt status bit positions
  localparam int IST_PULSE = 0;
  localparam int IST_CFG   = 1;
  // synchronised inputs: wake a, wake b, fail, level, pin
  localparam int NSYNC = 33;

  typedef enum logic [1:0] {
    EIP_MODE_INIT   = 2'h0,
    EIP_MODE_NORMAL = 2'h1,
    EIP_MODE_STOP   = 2'h2
  } eip_mode_t;

  typedef enum logic [2:0] {
    PS_IDLE = 3'b001,
    PS_LOW  = 3'b010,
    PS_GAP  = 3'b100
  } eip_pstate_t;

endpackage

/* File: eip_pulse_if.sv */
`timescale 1ns/10ps
// ==========================================================
// pulse request and state between control and generator
// ==========================================================
interface eip_pulse_if;
  logic req;   // a pulse is pending and allowed
  logic start; // generator takes the request
  logic low;   // pin phase is low
  logic busy;  // pulse or gap in progress
  modport ctl (output req, input start, input low, input busy);
  modport gen (input req, output start, output low, output busy);
endinterface

/* File: eip_pulser.sv */
`timescale 1ns/10ps
module eip_pulser
  import eip_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  eip_pulse_if.gen bus
);
  // ==========================================================
  // pulse and gap timer
  // ==========================================================
  eip_pstate_t      state_r;   // current phase
  eip_pstate_t      state_nxt; // next phase
  logic [CNT_W-1:0] cnt_r;     // cycles left in phase
  logic [CNT_W-1:0] cnt_nxt;   // next count
  logic             cnt_done;  // last cycle of phase

  assign cnt_done = (cnt_r == '0);

  // phase sequencing: low, then gap, then idle or low again
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r - 1'b1;
    unique case (state_r)
      PS_IDLE: begin
        cnt_nxt = cnt_r;
        if (bus.req) begin
          state_nxt = PS_LOW;
          cnt_nxt   = PULSE_CYC - 1'b1;
        end
      end
      PS_LOW: if (cnt_done) begin
        state_nxt = PS_GAP;
        cnt_nxt   = GAP_CYC - 1'b1;
      end
      PS_GAP: if (cnt_done) begin
        if (bus.req) begin
          state_nxt = PS_LOW;
          cnt_nxt   = PULSE_CYC - 1'b1;
        end else begin
          state_nxt = PS_IDLE;
          cnt_nxt   = cnt_r;
        end
      end
      // a broken one-hot code falls back to idle
      default: begin
        state_nxt = PS_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= PS_IDLE;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign bus.start = (state_nxt == PS_LOW) && (state_r != PS_LOW);
  assign bus.low   = (state_r == PS_LOW);
  assign bus.busy  = (state_r != PS_IDLE);

  // ==========================================================
  // checks
  // ==========================================================
  a_gap_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (state_r == PS_GAP) && !cnt_done |=> (state_r == PS_GAP))
    else $error("gap phase cut short");
  a_pending_served: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    bus.req && (state_r == PS_IDLE) |=> bus.low)
    else $error("pending pulse not started");
endmodule

/* File: eip_sync.sv */
`timescale 1ns/10ps
module eip_sync
  import eip_pkg::*;
#(
  parameter int W = NSYNC
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q,
  output logic      [W-1:0] o_rise
);
  // ==========================================================
  // two-stage synchroniser with rising edge detect
  // ==========================================================
  logic [W-1:0] meta_r; // first stage, read only by stage two
  logic [W-1:0] q_r;    // settled value
  logic [W-1:0] q_d_r;  // previous settled value

  // edges look at settled stages only
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      q_r    <= '0;
      q_d_r  <= '0;
    end else begin
      meta_r <= i_d;
      q_r    <= meta_r;
      q_d_r  <= q_r;
    end
  end

  assign o_q    = q_r;
  assign o_rise = q_r & ~q_d_r;
endmodule

/* File: eip_top.sv */
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
// Contract
// - low pulse of fixed 100 us width
// - at least 100 us high between pulses
// - pulses never change operating mode
// - class 0 pulses on every wake latch
// - only enabled wake sources latch and pulse
// - class 1 adds failure flags to pulses
// - pin level changes never pulse
// - restart and fail-safe flags never pulse
// - reset flag and device status never pulse
// - stop command with wake bits set pulses
// - readable status refreshed at pulse fall
// - events held until host clears them
// - init mode samples pin, 7 us filter
module eip_top
  import eip_pkg::*;
(
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst_n,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [DW-1:0] o_rdata,
  input  wire logic [RW-1:0] i_wake_a,
  input  wire logic [RW-1:0] i_wake_b,
  input  wire logic [RW-1:0] i_fail,
  input  wire logic [RW-1:0] i_pin_level,
  input  wire logic          i_int_pin,
  output logic               o_int_n,
  output logic               o_int_oe,
  output logic               o_irq
);
  // ==========================================================
  // helpers
  // ==========================================================
  // write-one-to-clear mask for a hit register
  function automatic logic [RW-1:0] clr_of(input logic hit, input logic [RW-1:0] d);
    return hit ? d : 8'h00;
  endfunction

  // ==========================================================
  // input synchronisation
  // ==========================================================
  logic [NSYNC-1:0] sync_q;    // settled pin levels
  logic [NSYNC-1:0] sync_rise; // settled rising edges
  eip_pulse_if      pbus ();   // link to the pulse timer

  eip_sync #(
    .W (NSYNC)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_d       ({i_int_pin, i_pin_level, i_fail, i_wake_b, i_wake_a}),
    .o_q       (sync_q),
    .o_rise    (sync_rise)
  );

  eip_pulser u_pulser (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .bus       (pbus)
  );

  wire logic [RW-1:0] rise_a  = sync_rise[7:0];   // wake group a edges
  wire logic [RW-1:0] rise_b  = sync_rise[15:8];  // wake group b edges
  wire logic [RW-1:0] rise_f  = sync_rise[23:16]; // failure edges
  wire logic [RW-1:0] level_s = sync_q[31:24];    // live pin levels
  wire logic          pin_s   = sync_q[32];       // config pin level

  // ==========================================================
  // registers
  // ==========================================================
  eip_mode_t        mode_r;      // operating mode
  logic             glb_r;       // interrupt class select
  logic [RW-1:0]    wake_en_a_r; // wake source enables a
  logic [RW-1:0]    wake_en_b_r; // wake source enables b
  logic [RW-1:0]    live_a_r;    // latched wake a
  logic [RW-1:0]    live_b_r;    // latched wake b
  logic [RW-1:0]    live_f_r;    // latched failures
  logic [RW-1:0]    shd_a_r;     // readable wake a
  logic [RW-1:0]    shd_b_r;     // readable wake b
  logic [RW-1:0]    shd_f_r;     // readable failures
  logic             pend_r;      // pulse owed to host
  logic [1:0]       irq_st_r;    // sticky interrupt status
  logic [1:0]       irq_msk_r;   // interrupt mask
  logic             cand_r;      // config level candidate
  logic [CNT_W-1:0] cfg_cnt_r;   // config stable count
  logic             cfg_sel_r;   // accepted config level
  logic             int_n_r;     // pin output flop
  logic             int_oe_r;    // pin enable flop
  logic             irq_r;       // interrupt output flop
  logic [DW-1:0]    rdata_r;     // read data flop

  // ==========================================================
  // address decode
  // ==========================================================
  wire logic hit_ctrl = i_wr && (i_addr == REG_CTRL);
  wire logic hit_en_a = i_wr && (i_addr == REG_WAKE_EN_A);
  wire logic hit_en_b = i_wr && (i_addr == REG_WAKE_EN_B);
  wire logic hit_msk  = i_wr && (i_addr == REG_IRQ_MSK);
  wire logic [RW-1:0] clr_a  = clr_of(i_wr && (i_addr == REG_WAKE_A), i_wdata[RW-1:0]);
  wire logic [RW-1:0] clr_b  = clr_of(i_wr && (i_addr == REG_WAKE_B), i_wdata[RW-1:0]);
  wire logic [RW-1:0] clr_f  = clr_of(i_wr && (i_addr == REG_FAIL), i_wdata[RW-1:0]);
  wire logic [RW-1:0] clr_is = clr_of(i_wr && (i_addr == REG_IRQ_ST), i_wdata[RW-1:0]);

  // mode field of a control write; code 3 is ignored
  wire logic [1:0] wr_mode  = i_wdata[CTRL_MODE_LSB +: 2];
  wire logic       mode_ok  = (wr_mode != 2'h3);
  wire logic       is_init  = (mode_r == EIP_MODE_INIT);

  // ==========================================================
  // event qualification
  // ==========================================================
  // enabled sources only
  wire logic [RW-1:0] new_a = rise_a & wake_en_a_r;
  wire logic [RW-1:0] new_b = rise_b & wake_en_b_r;
  wire logic [RW-1:0] new_f = glb_r ? (rise_f & FAIL_IRQ_BITS) : 8'h00;

  wire logic stop_cmd = hit_ctrl && (wr_mode == EIP_MODE_STOP);
  wire logic stop_chk = stop_cmd && (|(live_a_r | live_b_r));

  wire logic cause = (|new_a) || (|new_b) || (|new_f) || stop_chk;

  // ==========================================================
  // status next values
  // ==========================================================
  // held until cleared, set beats clear
  wire logic [RW-1:0] live_a_nxt = (live_a_r & ~clr_a) | new_a;
  wire logic [RW-1:0] live_b_nxt = (live_b_r & ~clr_b) | new_b;
  wire logic [RW-1:0] live_f_nxt = (live_f_r & ~clr_f) | rise_f;

  // refresh at pulse fall
  // status also tracks live values while no pulse is owed or running,
  // so events of a silent class stay visible to the host
  wire logic fall = pbus.low && int_n_r;
  wire logic load = fall || (!pend_r && !pbus.busy);

  wire logic [RW-1:0] shd_a_nxt = load ? live_a_nxt : (shd_a_r & ~clr_a);
  wire logic [RW-1:0] shd_b_nxt = load ? live_b_nxt : (shd_b_r & ~clr_b);
  wire logic [RW-1:0] shd_f_nxt = load ? live_f_nxt : (shd_f_r & ~clr_f);

  wire logic pend_nxt = cause || (pend_r && !pbus.start);
  assign pbus.req = pend_r && !is_init;

  // ==========================================================
  // configuration select filter
  // ==========================================================
  wire logic cfg_same = (pin_s == cand_r);
  wire logic cfg_full = (cfg_cnt_r == CFG_CYC - 1'b1);
  wire logic cfg_ev   = is_init && cfg_same && cfg_full && (cfg_sel_r != cand_r);

  // interrupt status events and output level
  wire logic [1:0] irq_ev     = {cfg_ev, fall};
  wire logic [1:0] irq_st_nxt = (irq_st_r & ~clr_is[1:0]) | irq_ev;

  // ==========================================================
  // read selection
  // ==========================================================
  wire logic [RW-1:0] ctrl_v = {5'h00, glb_r, mode_r};
  wire logic [RW-1:0] dev_v  = {3'h0, ~int_n_r, pend_r, cfg_sel_r, mode_r};
  wire logic [RW-1:0] rd_mux =
    (i_addr == REG_CTRL)      ? ctrl_v :
    (i_addr == REG_WAKE_EN_A) ? wake_en_a_r :
    (i_addr == REG_WAKE_EN_B) ? wake_en_b_r :
    (i_addr == REG_WAKE_A)    ? shd_a_r :
    (i_addr == REG_WAKE_B)    ? shd_b_r :
    (i_addr == REG_FAIL)      ? shd_f_r :
    (i_addr == REG_PIN_LVL)   ? level_s :
    (i_addr == REG_DEV)       ? dev_v :
    (i_addr == REG_IRQ_ST)    ? {6'h00, irq_st_r} :
    (i_addr == REG_IRQ_MSK)   ? {6'h00, irq_msk_r} :
    8'h00;

  // ==========================================================
  // control registers
  // ==========================================================
  // only software moves the mode
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r      <= EIP_MODE_INIT;
      glb_r       <= 1'b0;
      wake_en_a_r <= WAKE_EN_RST;
      wake_en_b_r <= WAKE_EN_RST;
      irq_msk_r   <= IRQ_MSK_RST[1:0];
    end else begin
      if (hit_ctrl && mode_ok) begin
        mode_r <= eip_mode_t'(wr_mode);
      end
      if (hit_ctrl) begin
        glb_r <= i_wdata[CTRL_GLB_BIT];
      end
      if (hit_en_a) begin
        wake_en_a_r <= i_wdata[RW-1:0];
      end
      if (hit_en_b) begin
        wake_en_b_r <= i_wdata[RW-1:0];
      end
      if (hit_msk) begin
        irq_msk_r <= i_wdata[1:0];
      end
    end
  end

  // ==========================================================
  // status latches and pending flag
  // ==========================================================
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      live_a_r <= '0;
      live_b_r <= '0;
      live_f_r <= '0;
      shd_a_r  <= '0;
      shd_b_r  <= '0;
      shd_f_r  <= '0;
      pend_r   <= 1'b0;
      irq_st_r <= 2'h0;
    end else begin
      live_a_r <= live_a_nxt;
      live_b_r <= live_b_nxt;
      live_f_r <= live_f_nxt;
      shd_a_r  <= shd_a_nxt;
      shd_b_r  <= shd_b_nxt;
      shd_f_r  <= shd_f_nxt;
      pend_r   <= pend_nxt;
      irq_st_r <= irq_st_nxt;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cand_r    <= 1'b0;
      cfg_cnt_r <= '0;
      cfg_sel_r <= 1'b0;
    end else if (!cfg_same) begin
      cand_r    <= pin_s;
      cfg_cnt_r <= '0;
    end else if (!cfg_full) begin
      cfg_cnt_r <= cfg_cnt_r + 1'b1;
    end else if (cfg_ev) begin
      cfg_sel_r <= cand_r;
    end
  end

  // ==========================================================
  // output flops
  // ==========================================================
  // pin drive is released in init so the strap can be read
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_n_r  <= 1'b1;
      int_oe_r <= 1'b0;
      irq_r    <= 1'b0;
      rdata_r  <= '0;
    end else begin
      int_n_r  <= !pbus.low;
      int_oe_r <= !is_init;
      irq_r    <= |(irq_st_r & irq_msk_r);
      rdata_r  <= i_rd ? {24'h000000, rd_mux} : 32'h00000000;
    end
  end

  assign o_int_n  = int_n_r;
  assign o_int_oe = int_oe_r;
  assign o_irq    = irq_r;
  assign o_rdata  = rdata_r;

  // ==========================================================
  // checks
  // ==========================================================
  logic [CNT_W-1:0] low_len_r; // cycles the pin stayed low
  logic [CNT_W-1:0] hi_len_r;  // high cycles, saturating

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_len_r <= '0;
      hi_len_r  <= GAP_CYC;
    end else begin
      low_len_r <= int_n_r ? '0 : low_len_r + 1'b1;
      hi_len_r  <= !int_n_r ? '0 : (hi_len_r == GAP_CYC) ? GAP_CYC : hi_len_r + 1'b1;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_stop_wake;
    stop_chk;
  endsequence
  sequence s_owed;
    pend_r ##1 1'b1;
  endsequence

  a_pulse_width: assert property ($rose(o_int_n) |-> low_len_r == PULSE_CYC)
    else $error("interrupt pulse width wrong");
  a_gap_min: assert property ($fell(o_int_n) |-> hi_len_r == GAP_CYC)
    else $error("high gap too short");
  a_mode_steady: assert property (!hit_ctrl |=> $stable(mode_r))
    else $error("mode changed without command");
  a_wake_pending: assert property ((|new_a) || (|new_b) |=> pend_r)
    else $error("wake latch did not request pulse");
  a_wake_enable: assert property (1'b1 |=> (live_a_r & ~$past(live_a_r) & ~$past(wake_en_a_r)) == 8'h00)
    else $error("disabled wake source latched");
  a_fail_class: assert property ((|new_f) |-> glb_r && ((new_f & ~FAIL_IRQ_BITS) == 8'h00))
    else $error("failure pulse outside global class");
  a_stop_wake: assert property (s_stop_wake |=> s_owed)
    else $error("stop with wake bits gave no pulse");
  a_status_load: assert property (fall && !i_wr |=> shd_a_r == $past(live_a_nxt))
    else $error("status not refreshed at fall");
  a_latch_hold: assert property (1'b1 |=> (($past(live_f_r) & ~live_f_r & ~$past(clr_f)) == 8'h00))
    else $error("latched event lost without clear");
  a_init_release: assert property (is_init |=> !o_int_oe)
    else $error("pin driven in init mode");
endmodule

/* File: event_interrupt_pulser_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module event_interrupt_pulser_tb
  import eip_pkg::*;
;
  // ==========================================================
  // signals
  // ==========================================================
  localparam int SETTLE = int'(PULSE_CYC) + int'(GAP_CYC) + 100; // one pulse plus gap
  logic          i_ref_clk, i_rst_n, i_wr, i_rd, o_int_n, o_int_oe, o_irq;
  logic [AW-1:0] i_addr;
  logic [DW-1:0] i_wdata, o_rdata;
  logic [RW-1:0] i_wake_a, i_wake_b, i_fail, i_pin_level;
  logic          pin, cfg_drv, cfg_lvl;
  int            hm_pulses, hm_low, hm_gap, fails, compares;

  eip_top dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_wake_a(i_wake_a), .i_wake_b(i_wake_b),
    .i_fail(i_fail), .i_pin_level(i_pin_level), .i_int_pin(pin), .o_int_n(o_int_n),
    .o_int_oe(o_int_oe), .o_irq(o_irq));
  eip_host_model host (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_int_n(o_int_n),
    .i_int_oe(o_int_oe), .i_cfg_drv(cfg_drv), .i_cfg_lvl(cfg_lvl), .o_pin(pin),
    .o_pulses(hm_pulses), .o_last_low(hm_low), .o_last_gap(hm_gap));

  // ==========================================================
  // bus tasks, one strobe cycle each
  // ==========================================================
  task automatic wr(input logic [AW-1:0] a, input logic [RW-1:0] v);
    @(posedge i_ref_clk);
    i_addr  <= a;
    i_wdata <= DW'(v);
    i_wr    <= 1'b1;
    @(posedge i_ref_clk);
    i_wr    <= 1'b0;
  endtask

  // data stands only in the cycle after the read edge
  task automatic rd(input logic [AW-1:0] a, output logic [RW-1:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_ref_clk);
    i_rd   <= 1'b0;
    // taken at the edge that closes the data cycle, so the bench stays on edges
    @(posedge i_ref_clk);
    d = o_rdata[RW-1:0];
  endtask

  task automatic rchk(input string nm, input logic [AW-1:0] a, input logic [RW-1:0] ex);
    logic [RW-1:0] d;
    rd(a, d);
    `CHK(nm, ex, d)
  endtask

  task automatic wait_fall(input int p);
    for (int k = 0; k < 50 && hm_pulses == p; k++) @(posedge i_ref_clk);
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_reset();
    `CHK("oe", 1'b0, o_int_oe)
    `CHK("int_n", 1'b1, o_int_n)
    rchk("ctrl", REG_CTRL, 8'h00);
    rchk("en_a", REG_WAKE_EN_A, WAKE_EN_RST);
    rchk("mask", REG_IRQ_MSK, IRQ_MSK_RST);
    rchk("unmapped", 8'h3C, 8'h00);
  endtask

  // short glitch refused, long level accepted, then irq masked/unmasked
  task automatic t_cfg();
    logic [RW-1:0] d;
    cfg_drv <= 1'b1;
    cfg_lvl <= 1'b1;
    repeat (100) @(posedge i_ref_clk);
    cfg_lvl <= 1'b0;
    rd(REG_DEV, d);
    `CHK("cfg glitch", 1'b0, d[2])
    cfg_lvl <= 1'b1;
    repeat (200) @(posedge i_ref_clk);
    rd(REG_DEV, d);
    `CHK("cfg level", 1'b1, d[2])
    `CHK("irq masked", 1'b0, o_irq)
    wr(REG_IRQ_MSK, 8'h02);
    repeat (3) @(posedge i_ref_clk);
    `CHK("irq cfg", 1'b1, o_irq)
    wr(REG_IRQ_MSK, 8'h00);
    wr(REG_IRQ_ST, 8'h02);
    cfg_drv <= 1'b0;
  endtask

  // wake in init stays pending; disabled source never latches
  task automatic t_wake();
    logic [RW-1:0] d;
    wr(REG_WAKE_EN_A, 8'h01);
    i_wake_a <= 8'h01;
    i_wake_b <= 8'h01;
    repeat (50) @(posedge i_ref_clk);
    `CHK("init pulses", 0, hm_pulses)
    wr(REG_CTRL, 8'h01);
    repeat (SETTLE) @(posedge i_ref_clk);
    `CHK("pulses", 1, hm_pulses)
    `CHK("low width", int'(PULSE_CYC), hm_low)
    `CHK("oe normal", 1'b1, o_int_oe)
    rd(REG_DEV, d);
    `CHK("mode", 2'h1, d[1:0])
    rchk("wake a", REG_WAKE_A, 8'h01);
    rchk("wake b", REG_WAKE_B, 8'h00);
    wr(REG_WAKE_A, 8'h01);
    rchk("reread", REG_WAKE_A, 8'h00);
  endtask

  // event in mid-pulse waits for the gap to elapse
  task automatic t_pending();
    int p;
    wr(REG_WAKE_EN_A, 8'hFF);
    p = hm_pulses;
    i_wake_a <= 8'h03;
    wait_fall(p);
    repeat (100) @(posedge i_ref_clk);
    i_wake_a <= 8'h07;
    repeat (2 * SETTLE) @(posedge i_ref_clk);
    `CHK("pend pulses", p + 2, hm_pulses)
    `CHK("gap", int'(GAP_CYC), hm_gap)
    wr(REG_WAKE_A, 8'hFF);
  endtask

  // class filter: only ordinary failures pulse, in class 1
  task automatic t_class();
    int p;
    p = hm_pulses;
    i_fail <= 8'h40;
    repeat (SETTLE) @(posedge i_ref_clk);
    `CHK("class0 fail", p, hm_pulses)
    wr(REG_FAIL, 8'hFF);
    wr(REG_CTRL, 8'h05);
    wr(REG_IRQ_ST, 8'h01);
    wr(REG_IRQ_MSK, 8'h01);
    i_fail      <= 8'h7F;
    i_pin_level <= 8'hA5;
    repeat (SETTLE) @(posedge i_ref_clk);
    `CHK("no pulse", p, hm_pulses)
    rchk("fail", REG_FAIL, 8'h3F);
    rchk("level", REG_PIN_LVL, 8'hA5);
    `CHK("irq idle", 1'b0, o_irq)
    i_fail <= 8'hFF;
    repeat (SETTLE) @(posedge i_ref_clk);
    `CHK("class1 fail", p + 1, hm_pulses)
    `CHK("irq set", 1'b1, o_irq)
    wr(REG_IRQ_ST, 8'h01);
    repeat (3) @(posedge i_ref_clk);
    `CHK("irq clear", 1'b0, o_irq)
  endtask

  // stop command with a wake bit still latched
  task automatic t_stop();
    int p;
    logic [RW-1:0] d;
    wr(REG_WAKE_EN_B, 8'h02);
    p = hm_pulses;
    i_wake_a <= 8'h0F;
    i_wake_b <= 8'h03;
    repeat (SETTLE) @(posedge i_ref_clk);
    rchk("wake b set", REG_WAKE_B, 8'h02);
    wr(REG_CTRL, 8'h06);
    repeat (SETTLE) @(posedge i_ref_clk);
    `CHK("stop pulses", p + 2, hm_pulses)
    rd(REG_DEV, d);
    `CHK("stop mode", 2'h2, d[1:0])
    // mode code 3 is refused, the mode must stay at stop
    wr(REG_CTRL, 8'h07);
    rd(REG_DEV, d);
    `CHK("mode 3 refused", 2'h2, d[1:0])
  endtask

  // ==========================================================
  // run control
  // ==========================================================
  task automatic close_out();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // clock, 50 ns period
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  // hang guard, about twice the expected run
  initial begin
    #3000000;
    fails++;
    close_out();
  end

  // main sequence
  initial begin
    {i_rst_n, i_wr, i_rd, cfg_drv, cfg_lvl} = '0;
    {i_addr, i_wdata, i_wake_a, i_wake_b, i_fail, i_pin_level} = '0;
    fails    = 0;
    compares = 0;
    repeat (2) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_cfg();
    t_wake();
    t_pending();
    t_class();
    t_stop();
    close_out();
  end
endmodule
